/* File: wcr_comparator.sv */
`timescale 1ns/1ps
module wcr_comparator
    import wcr_pkg::*;
#(
    parameter int MAX_IGN = 31
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // programming
    input wire logic ref_we,
    input wire logic ign_we,
    input wire logic act_we,
    input wire logic [31:0] wdata,
    input wire logic act_rd,
    // access stream
    input wire wcr_bus_s bus,
    // register view
    output logic [31:0] ref_val,
    output logic [WCR_IGN_W-1:0] ign_val,
    output logic [WCR_ACT_W-1:0] act_val,
    output logic matched,
    output logic hit
);

    typedef struct packed {
        logic [31:0] ref_v;
        logic [WCR_IGN_W-1:0] ign;
        logic [WCR_ACT_W-1:0] act;
        logic matched;
    } wcr_cmp_s;

    localparam logic [WCR_IGN_W-1:0] IGN_MAX = WCR_IGN_W'(MAX_IGN);

    wcr_cmp_s st_q;
    wcr_cmp_s st_d;
    logic [31:0] keep_mask;
    logic sel_hit;

    // masked compare: low bits dropped from the access address
    function automatic logic addr_eq(input logic [31:0] a, input logic [31:0] r,
                                     input logic [31:0] m);
        addr_eq = ((a & m) == r);
    endfunction

    // ------------------------------------------------------------
    // match selection
    // ------------------------------------------------------------
    always_comb
    begin
        keep_mask = 32'hffffffff << st_q.ign; // [RULE16]
        sel_hit = 1'b0;
        case (st_q.act) // [RULE15]
            WCR_ACT_IADDR: sel_hit = bus.ivalid && addr_eq(bus.iaddr, st_q.ref_v, keep_mask);
            WCR_ACT_DRD: sel_hit = bus.dvalid && bus.dread &&
                                    addr_eq(bus.daddr, st_q.ref_v, keep_mask);
            WCR_ACT_DWR: sel_hit = bus.dvalid && !bus.dread &&
                                    addr_eq(bus.daddr, st_q.ref_v, keep_mask);
            WCR_ACT_DRW: sel_hit = bus.dvalid && addr_eq(bus.daddr, st_q.ref_v, keep_mask);
            default: sel_hit = 1'b0; // disabled and reserved codes never match
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (ref_we)
            st_d.ref_v = wdata; // [RULE5]
        if (ign_we)
            // oversize requests clamp so software can probe the limit
            st_d.ign = (wdata[WCR_IGN_W-1:0] > IGN_MAX) ? IGN_MAX : wdata[WCR_IGN_W-1:0]; // [RULE9] [RULE10]
        if (act_we)
            st_d.act = wdata[WCR_ACT_W-1:0]; // [RULE13]
        if (act_rd)
            st_d.matched = 1'b0; // [RULE12]
        if (sel_hit)
            st_d.matched = 1'b1; // set beats the read clear [RULE11]
    end

    // reference and ignore size are not reset, only action and flag [RULE6]
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q.act <= WCR_ACT_OFF; // [RULE14]
            st_q.matched <= WCR_MATCH_RST; // [RULE19]
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign ref_val = st_q.ref_v;
    assign ign_val = st_q.ign;
    assign act_val = st_q.act;
    assign matched = st_q.matched;
    // unregistered here so the top's single flop keeps the hit in step with the flag
    assign hit = sel_hit;

endmodule

/* File: wcr_dbg_model.sv */
`timescale 1ns/1ps
module wcr_dbg_model
    import wcr_pkg::*;
(
    // clock
    input wire logic core_clk,
    // answer
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    // request
    output wcr_req_s req
);
    // ------------------------------------------------------------
    // debugger access tasks, each entered at a falling edge
    // ------------------------------------------------------------
    initial req = '0;

    // strobe held until the caller's next access, so back-to-back costs nothing
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, word: 1'b1};
        @(negedge core_clk);
    endtask

    // a missing answer comes back unknown so every compare on it fails
    task automatic rd(input logic [11:0] a, input logic w, output logic [31:0] d);
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~req.wdata, word: w};
        @(negedge core_clk);
        d = (rvalid === 1'b1) ? rdata : 'x;
    endtask

    // released lines flip so a stale value never looks like a live one
    task automatic idle();
        req = '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata, word: ~req.word};
        @(negedge core_clk);
    endtask
endmodule

/* File: wcr_pkg.sv */
package wcr_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets from the unit base; slot stride and in-slot offsets last)
    // ------------------------------------------------------------
    localparam logic [11:0] WCR_OFF_CTRL = 12'h000;
    localparam logic [11:0] WCR_OFF_PCS = 12'h01c;
    localparam logic [11:0] WCR_OFF_CMP0 = 12'h020;
    localparam logic [11:0] WCR_CMP_STRIDE = 12'h010;
    localparam logic [11:0] WCR_OFF_REF = 12'h000;
    localparam logic [11:0] WCR_OFF_IGN = 12'h004;
    localparam logic [11:0] WCR_OFF_ACT = 12'h008;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int WCR_CNT_LSB = 28;
    localparam int WCR_MATCH_BIT = 24;
    localparam int WCR_IGN_W = 5;
    localparam int WCR_ACT_W = 4;
    localparam logic [31:0] WCR_PCS_INVALID = 32'hffffffff;
    localparam logic [31:0] WCR_UNIMPL_READ = 32'h00000000;
    localparam logic WCR_MATCH_RST = 1'b0;

    // ------------------------------------------------------------
    // action select encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        WCR_ACT_OFF = 4'b0000,
        WCR_ACT_IADDR = 4'b0100,
        WCR_ACT_DRD = 4'b0101,
        WCR_ACT_DWR = 4'b0110,
        WCR_ACT_DRW = 4'b0111
    } wcr_act_e;

    // register access request from the debug port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic word;
    } wcr_req_s;

    // processor access stream
    typedef struct packed {
        logic ivalid;
        logic [31:0] iaddr;
        logic dvalid;
        logic dread;
        logic [31:0] daddr;
    } wcr_bus_s;

endpackage

/* File: wcr_regs.sv */
// Notes on behaviour
// RULE1 - pc sample register returns a full 32-bit recent instruction address, read only.
// RULE2 - pc sample contents are undefined after reset; no initial value expected.
// RULE3 - bit zero of the sample reads zero unless the all-ones invalid value.
// RULE4 - without pc sampling, the sample location reads zero and ignores writes.
// RULE5 - each comparator owns a 32-bit read/write reference address register.
// RULE6 - reference and ignore-size registers are undefined after reset.
// RULE7 - comparator registers exist only for indices zero to count minus one.
// RULE8 - slots beyond the count read unknown; debugger writes only zeros there.
// RULE9 - ignore-size register holds a 5-bit low field; upper 27 bits reserved.
// RULE10 - writing all ones to ignore size reads back the largest supported size.
// RULE11 - action register bit 24 is a read-only sticky flag set by a match.
// RULE12 - any read of the action register clears the flag, returning the old value.
// RULE13 - action register low four bits are read/write and select the match action.
// RULE14 - power-on reset clears the action select, disabling every comparator.
// RULE15 - encodings: 0 off, 4 instr, 5 data read, 6 data write, 7 both.
// RULE16 - match when the address with low ignore bits cleared equals the reference.
// RULE17 - pc sample accepts only word reads and discards every write.
// RULE18 - comparator count is reported in a read-only control register field.
// RULE19 - sticky match flag is reset to zero.
`timescale 1ns/1ps
module wcr_regs
    import wcr_pkg::*;
#(
    parameter int NUM_CMP = 4,
    parameter bit HAS_PCS = 1'b1,
    parameter int MAX_IGN = 31
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // debug access port request
    input wire wcr_req_s req,
    // processor streams
    input wire wcr_bus_s bus,
    input wire logic exec_valid,
    input wire logic [31:0] exec_addr,
    input wire logic sample_blocked,
    // debug access port answer
    output logic [31:0] rdata,
    output logic rvalid,
    // match events
    output logic [NUM_CMP-1:0] cmp_hit
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] pcs;
        logic [31:0] rdata;
        logic rvalid;
        logic [NUM_CMP-1:0] hit;
    } wcr_top_s;

    localparam logic [3:0] CNT_FIELD = 4'(NUM_CMP);

    wcr_top_s st_q;
    wcr_top_s st_d;
    logic [31:0] ref_v [NUM_CMP];
    logic [WCR_IGN_W-1:0] ign_v [NUM_CMP];
    logic [WCR_ACT_W-1:0] act_v [NUM_CMP];
    logic [NUM_CMP-1:0] matched_v;
    logic [NUM_CMP-1:0] hit_v;
    logic [NUM_CMP-1:0] ref_we;
    logic [NUM_CMP-1:0] ign_we;
    logic [NUM_CMP-1:0] act_we;
    logic [NUM_CMP-1:0] act_rd;

    // offset of register reg_off within comparator slot n
    function automatic logic [11:0] slot_addr(input int n, input logic [11:0] reg_off);
        slot_addr = WCR_OFF_CMP0 + 12'(n) * WCR_CMP_STRIDE + reg_off;
    endfunction

    // ------------------------------------------------------------
    // comparator slots
    // ------------------------------------------------------------
    // only implemented indices get hardware [RULE7]
    for (genvar g = 0; g < NUM_CMP; g++)
    begin : g_cmp
        assign ref_we[g] = req.wr && (req.addr == slot_addr(g, WCR_OFF_REF));
        assign ign_we[g] = req.wr && (req.addr == slot_addr(g, WCR_OFF_IGN));
        assign act_we[g] = req.wr && (req.addr == slot_addr(g, WCR_OFF_ACT));
        assign act_rd[g] = req.rd && (req.addr == slot_addr(g, WCR_OFF_ACT)); // [RULE12]

        wcr_comparator #(
            .MAX_IGN(MAX_IGN)
        ) u_cmp (
            .core_clk(core_clk),
            .rstn(rstn),
            .ref_we(ref_we[g]),
            .ign_we(ign_we[g]),
            .act_we(act_we[g]),
            .wdata(req.wdata),
            .act_rd(act_rd[g]),
            .bus(bus),
            .ref_val(ref_v[g]),
            .ign_val(ign_v[g]),
            .act_val(act_v[g]),
            .matched(matched_v[g]),
            .hit(hit_v[g])
        );
    end

    // ------------------------------------------------------------
    // next state and read mux
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.hit = hit_v;
        st_d.rvalid = req.rd;
        // sampling: blocked states give the invalid pattern, else halfword pc
        if (sample_blocked)
            st_d.pcs = WCR_PCS_INVALID; // [RULE3]
        else if (exec_valid)
            st_d.pcs = {exec_addr[31:1], 1'b0}; // [RULE1] [RULE3]
        if (req.rd)
        begin
            // unmapped and unimplemented slots read zero [RULE8]
            st_d.rdata = WCR_UNIMPL_READ;
            if (req.addr == WCR_OFF_CTRL)
                st_d.rdata = {CNT_FIELD, 28'h0000000}; // [RULE18]
            else if (req.addr == WCR_OFF_PCS)
                // sub-word reads are not defined; return zero for them [RULE17]
                st_d.rdata = (HAS_PCS && req.word) ? st_q.pcs : 32'h00000000; // [RULE4]
            for (int n = 0; n < NUM_CMP; n++)
            begin
                if (req.addr == slot_addr(n, WCR_OFF_REF))
                    st_d.rdata = ref_v[n];
                if (req.addr == slot_addr(n, WCR_OFF_IGN))
                    st_d.rdata = {27'h0000000, ign_v[n]}; // [RULE9]
                if (req.addr == slot_addr(n, WCR_OFF_ACT))
                    st_d.rdata = {7'h00, matched_v[n], 20'h00000, act_v[n]}; // [RULE11]
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // answer path resets; writes to control and sample are simply not decoded [RULE17]
    // the sample holds no reset value [RULE2]
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q.rdata <= 32'h00000000;
            st_q.rvalid <= 1'b0;
            st_q.hit <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign rvalid = st_q.rvalid;
    assign cmp_hit = st_q.hit;

endmodule

/* File: wcr_regs_properties.sv */
`timescale 1ns/1ps
module wcr_regs_properties
    import wcr_pkg::*;
#(
    parameter int NUM_CMP = 4,
    parameter bit HAS_PCS = 1'b1
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // inputs
    input wire wcr_req_s req,
    input wire wcr_bus_s bus,
    input wire logic exec_valid,
    input wire logic [31:0] exec_addr,
    input wire logic sample_blocked,
    // outputs
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic [NUM_CMP-1:0] cmp_hit
);
    // ------------------------------------------------------------
    // register bus and match event checks
    // ------------------------------------------------------------
    localparam logic [11:0] ACT0 = WCR_OFF_CMP0 + WCR_OFF_ACT;
    localparam logic [11:0] SLOT_END = WCR_OFF_CMP0 + WCR_CMP_STRIDE * 12'(NUM_CMP);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // read of comparator 0 action register
    sequence s_act_rd;
        req.rd && req.addr == ACT0;
    endsequence

    a_read_answer: assert property (req.rd |=> rvalid) else $error("read not answered");
    a_no_stray: assert property (!req.rd |=> !rvalid) else $error("stray read answer");
    a_count_field: assert property (req.rd && req.addr == WCR_OFF_CTRL
        |=> rdata[31:28] == 4'(NUM_CMP)) else $error("bad count field");
    a_sample_bit0: assert property (req.rd && req.addr == WCR_OFF_PCS
        |=> rdata == WCR_PCS_INVALID || !rdata[0]) else $error("sample bit 0 set");
    a_sample_blocked: assert property (sample_blocked && $past(sample_blocked)
        ##0 req.rd && req.addr == WCR_OFF_PCS && req.word
        |=> rdata == (HAS_PCS ? WCR_PCS_INVALID : 32'h0)) else $error("blocked sample");
    a_sample_narrow: assert property (req.rd && req.addr == WCR_OFF_PCS && !req.word
        |=> rdata == 32'h0) else $error("narrow sample read not zero");
    a_unmapped_zero: assert property (req.rd && (req.addr == 12'h010 || req.addr == SLOT_END)
        |=> rdata == WCR_UNIMPL_READ) else $error("unmapped read not zero");
    a_hit_cause: assert property (|cmp_hit |-> $past(bus.ivalid || bus.dvalid))
        else $error("hit without access");
    a_flag_set: assert property (cmp_hit[0] ##0 s_act_rd |=> rdata[WCR_MATCH_BIT])
        else $error("match flag not set");
    a_flag_clear: assert property (s_act_rd ##1 s_act_rd ##0 !cmp_hit[0]
        |=> !rdata[WCR_MATCH_BIT]) else $error("match flag not cleared");
endmodule

bind wcr_regs wcr_regs_properties #(.NUM_CMP(NUM_CMP), .HAS_PCS(HAS_PCS)) u_props (
    .core_clk(core_clk), .rstn(rstn), .req(req), .bus(bus), .exec_valid(exec_valid),
    .exec_addr(exec_addr), .sample_blocked(sample_blocked), .rdata(rdata),
    .rvalid(rvalid), .cmp_hit(cmp_hit)
);

/* File: wcr_regs_tb.sv */
`timescale 1ns/1ps
module wcr_regs_tb
    import wcr_pkg::*;
();
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    localparam int NUM_CMP = 2;
    localparam int MAX_IGN = 12;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    wcr_req_s req;
    wcr_bus_s bus = '0;
    logic exec_valid = 1'b0;
    logic [31:0] exec_addr = 32'h0;
    logic sample_blocked = 1'b0;
    logic [31:0] rdata;
    logic rvalid;
    logic [NUM_CMP-1:0] cmp_hit;
    logic [31:0] got;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    wcr_act_e acts [5] = '{WCR_ACT_IADDR, WCR_ACT_DRD, WCR_ACT_DWR, WCR_ACT_DRW, WCR_ACT_OFF};

    wcr_regs #(.NUM_CMP(NUM_CMP), .HAS_PCS(1'b1), .MAX_IGN(MAX_IGN)) DUT (
        .core_clk(core_clk), .rstn(rstn), .req(req), .bus(bus), .exec_valid(exec_valid),
        .exec_addr(exec_addr), .sample_blocked(sample_blocked), .rdata(rdata),
        .rvalid(rvalid), .cmp_hit(cmp_hit)
    );
    wcr_dbg_model dbg (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    // hang guard: the sequence needs about 130 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            $display("wrong value at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    function automatic logic [11:0] cadr(input int n, input logic [11:0] off);
        return WCR_OFF_CMP0 + WCR_CMP_STRIDE * 12'(n) + off;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic t_reset();
        dbg.wr(WCR_OFF_CTRL, 32'hffff_ffff); // control is read only
        dbg.rd(WCR_OFF_CTRL, 1'b1, got);
        chk(32'(got[31:28]), 32'(NUM_CMP));
        for (int n = 0; n < NUM_CMP; n++)
        begin
            dbg.rd(cadr(n, WCR_OFF_ACT), 1'b1, got);
            chk(32'({got[WCR_MATCH_BIT], got[3:0]}), 32'h0);
        end
    endtask

    task automatic t_regs();
        for (int n = 0; n < NUM_CMP; n++)
        begin
            dbg.wr(cadr(n, WCR_OFF_REF), 32'h2000_0040 + 32'(n));
            dbg.wr(cadr(n, WCR_OFF_IGN), 32'hffff_ffff);
            dbg.rd(cadr(n, WCR_OFF_REF), 1'b1, got);
            chk(got, 32'h2000_0040 + 32'(n));
            dbg.rd(cadr(n, WCR_OFF_IGN), 1'b1, got);
            chk(32'(got[4:0]), 32'(MAX_IGN));
            foreach (acts[i])
            begin
                dbg.wr(cadr(n, WCR_OFF_ACT), 32'(acts[i]));
                dbg.rd(cadr(n, WCR_OFF_ACT), 1'b1, got);
                chk(32'(got[3:0]), 32'(acts[i]));
            end
        end
    endtask

    // every action against every access kind, then one address just outside the range
    task automatic t_match();
        wcr_act_e a;
        int k;
        logic [31:0] ad;
        logic hit;
        dbg.wr(cadr(0, WCR_OFF_REF), 32'h2000_0040);
        dbg.wr(cadr(0, WCR_OFF_IGN), 32'h0000_0004);
        for (int c = 0; c < 16; c++)
        begin
            a = acts[(c / 3) % 5];
            k = c % 3;
            ad = (c == 15) ? 32'h2000_0050 : 32'h2000_004c;
            hit = ad == 32'h2000_004c && ((k == 0 && a == WCR_ACT_IADDR)
                || (k == 1 && (a == WCR_ACT_DRD || a == WCR_ACT_DRW))
                || (k == 2 && (a == WCR_ACT_DWR || a == WCR_ACT_DRW)));
            dbg.wr(cadr(0, WCR_OFF_ACT), 32'(a));
            dbg.idle();
            bus = '{ivalid: k == 0, iaddr: ad, dvalid: k != 0, dread: k == 1, daddr: ad};
            @(negedge core_clk);
            bus.ivalid = 1'b0;
            bus.dvalid = 1'b0;
            dbg.rd(cadr(0, WCR_OFF_ACT), 1'b1, got);
            chk(32'(got[WCR_MATCH_BIT]), 32'(hit));
            dbg.rd(cadr(0, WCR_OFF_ACT), 1'b1, got);
            chk(32'(got[WCR_MATCH_BIT]), 32'h0);
        end
    endtask

    // the sample is never read before the first executed address lands
    task automatic t_sample();
        exec_addr = 32'h1234_5679;
        exec_valid = 1'b1;
        dbg.idle();
        exec_valid = 1'b0;
        dbg.idle();
        dbg.wr(WCR_OFF_PCS, 32'h0);
        dbg.rd(WCR_OFF_PCS, 1'b1, got);
        chk(got, 32'h1234_5678);
        dbg.rd(WCR_OFF_PCS, 1'b0, got);
        chk(got, 32'h0);
        sample_blocked = 1'b1;
        dbg.idle();
        dbg.rd(WCR_OFF_PCS, 1'b1, got);
        chk(got, WCR_PCS_INVALID);
        sample_blocked = 1'b0;
        dbg.wr(cadr(NUM_CMP, WCR_OFF_REF), 32'h0);
        dbg.rd(cadr(NUM_CMP, WCR_OFF_REF), 1'b1, got);
        chk(got, WCR_UNIMPL_READ);
        dbg.rd(12'h010, 1'b1, got);
        chk(got, WCR_UNIMPL_READ);
        dbg.idle();
    endtask

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_match();
        t_sample();
        end_of_test();
    end
endmodule
